// File: lin_cfg_pkg.sv
// constants and register map for the lin configuration and write-protect block
// Summary of operation
// [R1] dma writes lin mode only when dma mode set
// [R2] length field plus one when source bit zero
// [R3] source bit one: length from identifier bits five:four
// [R4] wakeup command sends 2.0 or 1.3 wakeup
// [R5] frame slot mode runs unless disabled
// [R6] checksum type selects enhanced or classic
// [R7] checksum disable skips generation and checking
// [R8] parity disable skips identifier parity handling
// [R9] node action selects transmit, receive, ignore, reserved
// [R10] identifier writable as master, received value as slave
// [R11] protect enable written only with correct key
// [R12] protection guards mode, baud, timeout, timeguard writes
// [R13] violation flag set until status next read
// [R14] violation source holds offset of failed write
// [R15] status read clears flag and source
// [R16] read-only version register, no behaviour
// [R17] receiver timeout value is seventeen bits wide
// [R18] peripheral clock divided by eight offered
// [R19] identifier flag set on identifier, cleared by reset-status
// [R20] blocked writes leave registers unchanged
package lin_cfg_pkg;
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_BAUD = 8'h20;
    localparam logic [7:0] OFF_TIMEOUT = 8'h24;
    localparam logic [7:0] OFF_GUARD = 8'h28;
    localparam logic [7:0] OFF_LIN_MODE = 8'h54;
    localparam logic [7:0] OFF_LIN_ID = 8'h58;
    localparam logic [7:0] OFF_CTRL = 8'h60;
    localparam logic [7:0] OFF_STATUS = 8'h64;
    localparam logic [7:0] OFF_PROT_MODE = 8'he4;
    localparam logic [7:0] OFF_PROT_STATUS = 8'he8;
    localparam logic [7:0] OFF_REVISION = 8'hfc;
    localparam logic [23:0] PROTECT_KEY = 24'h555341;
    localparam int KEY_LSB = 8;
    localparam int BIT_PROT_EN = 0;
    localparam int BIT_NODE_ACTION_LSB = 0;
    localparam int BIT_PARITY_DISABLE = 2;
    localparam int BIT_CHECKSUM_DISABLE = 3;
    localparam int BIT_CHECKSUM_TYPE_SELECT = 4;
    localparam int BIT_LENSRC = 5;
    localparam int BIT_FRAME_SLOT_DISABLE = 6;
    localparam int BIT_WKTYP = 7;
    localparam int LEN_LSB = 8;
    localparam int BIT_DMAMODE = 16;
    localparam int BIT_CTRL_WAKEUP = 0;
    localparam int BIT_CTRL_RSTSTA = 1;
    localparam int BIT_STAT_IDSEEN = 0;
    localparam int VSRC_LSB = 8;
    localparam int TIMEOUT_W = 17;
    localparam int CLK_DIV = 8;
    localparam logic [16:0] LIN_MODE_MASK = 17'h1ffff;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [11:0] REVISION_VALUE = 12'h123; // arbitrary
    localparam logic [3:0] REVISION_RSVD = 4'h0;
    typedef enum logic [1:0] {
        NODE_ACTION_TRANSMIT = 2'h0,
        NODE_ACTION_RECEIVE = 2'h1,
        NODE_ACTION_IGNORE = 2'h2,
        NODE_ACTION_RESERVED = 2'h3
    } node_action_t;
endpackage : lin_cfg_pkg

// File: lin_frame_config_write_protect.sv
// lin configuration, identifier and write-protect register block on apb
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module lin_frame_config_write_protect (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic masterMode,
    input wire logic dmaWrite,
    input wire logic [16:0] dmaWdata,
    input wire logic idReceived,
    input wire logic [7:0] idReceivedChar,
    input wire logic idSent,
    output logic [8:0] responseLength,
    output logic wakeupPulse,
    output logic wakeupLin13,
    output logic frameSlotEnable,
    output logic checksumClassic,
    output logic checksumEnable,
    output logic parityEnable,
    output logic txResponse,
    output logic rxResponse,
    output logic [7:0] identifierCharacter,
    output logic identifierSeenFlag,
    output logic [31:0] modeValue,
    output logic [19:0] baudValue,
    output logic [16:0] rxTimeoutValue,
    output logic [7:0] guardValue,
    output logic dividedClockTick
);
    logic [16:0] linMode_q;
    logic [7:0] identifier_seen_flag_q;
    logic protectEnable_q;
    logic violation_q;
    logic [15:0] violationSrc_q;
    logic idSeen_q;
    logic wakeup_q;
    logic [31:0] mode_q;
    logic [19:0] baud_q;
    logic [16:0] timeout_q;
    logic [7:0] guard_q;
    logic [2:0] div_q;
    logic tick_q;
    logic wrEn;
    logic rdEn;
    logic rdSetup;
    logic protHit;
    logic mapped;
    logic [31:0] rdata_d;
    logic wrMode;
    logic wrBaud;
    logic wrTimeout;
    logic wrGuard;
    logic wrLinMode;
    logic wrLinId;
    logic wrProtMode;
    logic wrCtrl;
    logic keyMatch;
    logic guardedWrite;
    logic statusRead;
    logic dmaLand;
    logic idEvent;
    logic [7:0] lenField;
    logic lenSource;
    logic [1:0] idLenBits;
    lin_cfg_pkg::node_action_t node_action;

    // single-cycle access phase: zero wait states
    assign pready = 1'b1;
    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & penable & ~pwrite;
    // read word captured in setup, so it already stands at the access edge
    assign rdSetup = psel & ~penable & ~pwrite;
    assign protHit = (paddr == lin_cfg_pkg::OFF_MODE) | (paddr == lin_cfg_pkg::OFF_BAUD)
        | (paddr == lin_cfg_pkg::OFF_TIMEOUT) | (paddr == lin_cfg_pkg::OFF_GUARD);

    assign wrMode = wrEn & (paddr == lin_cfg_pkg::OFF_MODE);
    assign wrBaud = wrEn & (paddr == lin_cfg_pkg::OFF_BAUD);
    assign wrTimeout = wrEn & (paddr == lin_cfg_pkg::OFF_TIMEOUT);
    assign wrGuard = wrEn & (paddr == lin_cfg_pkg::OFF_GUARD);
    assign wrLinMode = wrEn & (paddr == lin_cfg_pkg::OFF_LIN_MODE);
    assign wrLinId = wrEn & (paddr == lin_cfg_pkg::OFF_LIN_ID);
    assign wrProtMode = wrEn & (paddr == lin_cfg_pkg::OFF_PROT_MODE);
    assign wrCtrl = wrEn & (paddr == lin_cfg_pkg::OFF_CTRL);
    assign keyMatch = (pwdata[31:lin_cfg_pkg::KEY_LSB] == lin_cfg_pkg::PROTECT_KEY);
    assign guardedWrite = wrEn & protectEnable_q & protHit;
    assign statusRead = rdEn & (paddr == lin_cfg_pkg::OFF_PROT_STATUS);
    assign dmaLand = dmaWrite & linMode_q[lin_cfg_pkg::BIT_DMAMODE];
    assign idEvent = (masterMode & idSent) | (~masterMode & idReceived);

    // decode kept apart from the data mux so the error answer is easy to audit
    always_comb begin
        unique case (paddr)
            lin_cfg_pkg::OFF_MODE,
            lin_cfg_pkg::OFF_BAUD,
            lin_cfg_pkg::OFF_TIMEOUT,
            lin_cfg_pkg::OFF_GUARD,
            lin_cfg_pkg::OFF_LIN_MODE,
            lin_cfg_pkg::OFF_LIN_ID,
            lin_cfg_pkg::OFF_CTRL,
            lin_cfg_pkg::OFF_STATUS,
            lin_cfg_pkg::OFF_PROT_MODE,
            lin_cfg_pkg::OFF_PROT_STATUS,
            lin_cfg_pkg::OFF_REVISION: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            lin_cfg_pkg::OFF_MODE: rdata_d = mode_q;
            lin_cfg_pkg::OFF_BAUD: rdata_d = {12'h000, baud_q};
            lin_cfg_pkg::OFF_TIMEOUT: rdata_d = {15'h0000, timeout_q};
            lin_cfg_pkg::OFF_GUARD: rdata_d = {24'h000000, guard_q};
            lin_cfg_pkg::OFF_LIN_MODE: rdata_d = {15'h0000, linMode_q};
            lin_cfg_pkg::OFF_LIN_ID: rdata_d = {24'h000000, identifier_seen_flag_q};
            lin_cfg_pkg::OFF_CTRL: rdata_d = 32'h0000_0000;
            lin_cfg_pkg::OFF_STATUS: rdata_d = {31'h0000_0000, idSeen_q};
            // key reads back as zero
            lin_cfg_pkg::OFF_PROT_MODE: rdata_d = {31'h0000_0000, protectEnable_q}; // R11
            lin_cfg_pkg::OFF_PROT_STATUS: rdata_d = {8'h00, violationSrc_q, 7'h00, violation_q};
            lin_cfg_pkg::OFF_REVISION:
                rdata_d = {12'h000, lin_cfg_pkg::REVISION_RSVD, 4'h0,
                           lin_cfg_pkg::REVISION_VALUE}; // R16
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // unmapped addresses answer with an error, reads as zero
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rdSetup) begin
            prdata <= rdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            linMode_q <= 17'h00000;
        end else if (wrLinMode) begin
            linMode_q <= pwdata[16:0];
        end else if (dmaLand) begin
            // the dma mode bit itself is never touched by dma
            linMode_q <= {1'b1, dmaWdata[15:0]}; // R1
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            identifier_seen_flag_q <= 8'h00;
        end else if (!masterMode && idReceived) begin
            identifier_seen_flag_q <= idReceivedChar; // R10
        end else if (masterMode && wrLinId) begin
            identifier_seen_flag_q <= pwdata[7:0]; // R10
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            protectEnable_q <= 1'b0;
        end else if (wrProtMode && keyMatch) begin
            protectEnable_q <= pwdata[lin_cfg_pkg::BIT_PROT_EN]; // R11 R20
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= lin_cfg_pkg::MODE_RESET;
        end else if (wrMode && !protectEnable_q) begin
            mode_q <= pwdata; // R12 R20
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            baud_q <= 20'h00000;
        end else if (wrBaud && !protectEnable_q) begin
            baud_q <= pwdata[19:0]; // R12 R20
        end
    end

    // counter width fixed; upper write bits are dropped, not saturated
    always_ff @(posedge clk) begin
        if (rst) begin
            timeout_q <= 17'h00000;
        end else if (wrTimeout && !protectEnable_q) begin
            timeout_q <= pwdata[lin_cfg_pkg::TIMEOUT_W-1:0]; // R12 R17 R20
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            guard_q <= 8'h00;
        end else if (wrGuard && !protectEnable_q) begin
            guard_q <= pwdata[7:0]; // R12 R20
        end
    end

    // a violation in the same cycle as the status read wins
    always_ff @(posedge clk) begin
        if (rst) begin
            violation_q <= 1'b0;
        end else if (guardedWrite) begin
            violation_q <= 1'b1; // R13
        end else if (statusRead) begin
            violation_q <= 1'b0; // R15
        end
    end

    // only the last blocked address is kept; earlier ones are overwritten
    always_ff @(posedge clk) begin
        if (rst) begin
            violationSrc_q <= 16'h0000;
        end else if (guardedWrite) begin
            violationSrc_q <= {8'h00, paddr}; // R14
        end else if (statusRead) begin
            violationSrc_q <= 16'h0000; // R15
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            idSeen_q <= 1'b0;
        end else if (idEvent) begin
            idSeen_q <= 1'b1; // R19
        end else if (wrCtrl && pwdata[lin_cfg_pkg::BIT_CTRL_RSTSTA]) begin
            idSeen_q <= 1'b0; // R19
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wakeup_q <= 1'b0;
        end else begin
            wakeup_q <= wrCtrl && pwdata[lin_cfg_pkg::BIT_CTRL_WAKEUP]; // R4
        end
    end

    // free-running divider; the tick is a strobe, not a derived clock
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1; // R18
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 3'(lin_cfg_pkg::CLK_DIV - 1)); // R18
        end
    end

    assign node_action = lin_cfg_pkg::node_action_t'(linMode_q[lin_cfg_pkg::BIT_NODE_ACTION_LSB +: 2]);

    // reserved code is treated as ignore so the node never drives a stray response
    always_comb begin
        unique case (node_action) // R9
            lin_cfg_pkg::NODE_ACTION_TRANSMIT: begin
                txResponse = 1'b1;
                rxResponse = 1'b0;
            end
            lin_cfg_pkg::NODE_ACTION_RECEIVE: begin
                txResponse = 1'b0;
                rxResponse = 1'b1;
            end
            lin_cfg_pkg::NODE_ACTION_IGNORE: begin
                txResponse = 1'b0;
                rxResponse = 1'b0;
            end
            lin_cfg_pkg::NODE_ACTION_RESERVED: begin
                txResponse = 1'b0;
                rxResponse = 1'b0;
            end
        endcase
    end

    assign parityEnable = ~linMode_q[lin_cfg_pkg::BIT_PARITY_DISABLE]; // R8
    assign checksumEnable = ~linMode_q[lin_cfg_pkg::BIT_CHECKSUM_DISABLE]; // R7
    assign checksumClassic = linMode_q[lin_cfg_pkg::BIT_CHECKSUM_TYPE_SELECT]; // R6
    assign frameSlotEnable = ~linMode_q[lin_cfg_pkg::BIT_FRAME_SLOT_DISABLE]; // R5
    assign wakeupLin13 = linMode_q[lin_cfg_pkg::BIT_WKTYP]; // R4
    assign wakeupPulse = wakeup_q;

    assign lenField = linMode_q[lin_cfg_pkg::LEN_LSB +: 8];
    assign lenSource = linMode_q[lin_cfg_pkg::BIT_LENSRC];
    assign idLenBits = identifier_seen_flag_q[5:4];

    // identifier bits five:four give 2, 2, 4 or 8 bytes
    always_comb begin
        if (lenSource) begin
            unique case (idLenBits) // R3
                2'h0: responseLength = 9'h002;
                2'h1: responseLength = 9'h002;
                2'h2: responseLength = 9'h004;
                default: responseLength = 9'h008;
            endcase
        end else begin
            responseLength = {1'b0, lenField} + 9'h001; // R2
        end
    end
    assign identifierCharacter = identifier_seen_flag_q;
    assign identifierSeenFlag = idSeen_q;
    assign modeValue = mode_q;
    assign baudValue = baud_q;
    assign rxTimeoutValue = timeout_q;
    assign guardValue = guard_q;
    assign dividedClockTick = tick_q;
endmodule : lin_frame_config_write_protect

// File: lin_cfg_asserts.sv
// concurrent checks on the lin configuration block ports
`timescale 1ns/100ps
module lin_cfg_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic idSent,
    input wire logic [8:0] responseLength,
    input wire logic wakeupPulse,
    input wire logic checksumClassic,
    input wire logic checksumEnable,
    input wire logic parityEnable,
    input wire logic txResponse,
    input wire logic rxResponse,
    input wire logic identifierSeenFlag,
    input wire logic [19:0] baudValue,
    input wire logic dividedClockTick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic wr;
    logic protQ;
    assign wr = psel && penable && pwrite;
    // shadow of protect enable, tracked from bus writes alone
    always_ff @(posedge clk) begin
        if (rst)
            protQ <= 1'b0;
        else if (wr && paddr == 8'he4 && pwdata[31:8] == 24'h555341)
            protQ <= pwdata[0];
    end
    lin_bits_a: assert property (wr && paddr == 8'h54 |=>
        checksumClassic == $past(pwdata[4]) && checksumEnable != $past(pwdata[3])
        && parityEnable != $past(pwdata[2])) else $error("lin mode bits not applied");
    field_len_a: assert property (wr && paddr == 8'h54 && !pwdata[5] |=>
        responseLength == {1'b0, $past(pwdata[15:8])} + 9'd1) else $error("length wrong");
    node_act_a: assert property (wr && paddr == 8'h54 |=>
        txResponse == ($past(pwdata[1:0]) == 2'h0) && rxResponse == ($past(pwdata[1:0]) == 2'h1))
        else $error("node action wrong");
    guard_block_a: assert property (wr && protQ && paddr == 8'h20 |=> $stable(baudValue))
        else $error("protected write landed");
    guard_open_a: assert property (wr && !protQ && paddr == 8'h20 |=>
        baudValue == $past(pwdata[19:0])) else $error("open write lost");
    clk_div_a: assert property (dividedClockTick |=> !dividedClockTick [*7] ##1 dividedClockTick)
        else $error("divided tick spacing");
    wake_pulse_a: assert property (wr && paddr == 8'h60 && pwdata[0] |=>
        wakeupPulse ##1 !wakeupPulse) else $error("wakeup pulse wrong");
    id_seen_a: assert property (idSent |=> identifierSeenFlag)
        else $error("identifier flag not set");
    cover property (wr && protQ && paddr == 8'h24);
    cover property (wr && paddr == 8'h54 && pwdata[5]);
    cover property (idSent);
endmodule : lin_cfg_asserts

// File: lin_node_model.sv
// far side: dma channel and lin bus identifier events
`timescale 1ns/100ps
module lin_node_model (
    input wire logic clk,
    output logic dmaWrite,
    output logic [16:0] dmaWdata,
    output logic idReceived,
    output logic [7:0] idReceivedChar,
    output logic idSent
);
    initial begin
        {dmaWrite, idReceived, idSent} = 3'h0;
        dmaWdata = 17'h0;
        idReceivedChar = 8'h0;
    end
    // one-cycle dma word; the device decides whether it lands
    task automatic dmaPut(input logic [16:0] v);
        @(posedge clk);
        dmaWrite <= 1'b1;
        dmaWdata <= v;
        @(posedge clk);
        dmaWrite <= 1'b0;
        dmaWdata <= ~v;
    endtask : dmaPut
    // data shows inverted once released so stale values never match
    task automatic idEvent(input logic rx, input logic [7:0] c);
        @(posedge clk);
        idReceived <= rx;
        idSent <= !rx;
        idReceivedChar <= c;
        @(posedge clk);
        idReceived <= 1'b0;
        idSent <= 1'b0;
        idReceivedChar <= ~c;
    endtask : idEvent
endmodule : lin_node_model

// File: tb_top.sv
// self-checking bench for the lin configuration and write-protect block
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
    logic clk, rst, psel, penable, pwrite, masterMode, serr, pready, pslverr, wakeupPulse;
    logic wakeupLin13, frameSlotEnable, checksumClassic, checksumEnable, parityEnable;
    logic txResponse, rxResponse, identifierSeenFlag, dividedClockTick, dmaWrite, idReceived;
    logic idSent;
    logic [7:0] paddr, id, identifierCharacter, guardValue, idReceivedChar;
    logic [31:0] pwdata, prdata, d, v, ver, modeValue;
    logic [8:0] responseLength;
    logic [16:0] rxTimeoutValue, dmaWdata;
    logic [19:0] baudValue;
    int failures, n_tests;
    logic [7:0] regA [9] = '{8'h00, 8'h20, 8'h24, 8'h28, 8'h54, 8'h58, 8'he4, 8'he8, 8'hfc};
    logic [7:0] gA [4] = '{8'h00, 8'h20, 8'h24, 8'h28};
    logic [31:0] gE [4] = '{32'h0, 32'h51234, 32'h1ffff, 32'h0};
    lin_frame_config_write_protect u_lin_frame_config_write_protect (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .masterMode(masterMode),
        .dmaWrite(dmaWrite), .dmaWdata(dmaWdata), .idReceived(idReceived),
        .idReceivedChar(idReceivedChar), .idSent(idSent), .responseLength(responseLength),
        .wakeupPulse(wakeupPulse), .wakeupLin13(wakeupLin13), .frameSlotEnable(frameSlotEnable),
        .checksumClassic(checksumClassic), .checksumEnable(checksumEnable),
        .parityEnable(parityEnable), .txResponse(txResponse), .rxResponse(rxResponse),
        .identifierCharacter(identifierCharacter), .identifierSeenFlag(identifierSeenFlag),
        .modeValue(modeValue), .baudValue(baudValue), .rxTimeoutValue(rxTimeoutValue),
        .guardValue(guardValue), .dividedClockTick(dividedClockTick));
    lin_node_model u_lin_node_model (.clk(clk), .dmaWrite(dmaWrite), .dmaWdata(dmaWdata),
        .idReceived(idReceived), .idReceivedChar(idReceivedChar), .idSent(idSent));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // read data and error are taken at the access edge; outputs checked at the next fall
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            if (++n > 64) begin
                failures++;
                final_report();
            end
            @(posedge clk);
        end
        serr = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb
    function automatic logic [8:0] expLen(input logic [31:0] m, input logic [7:0] c);
        if (!m[5])
            return {1'b0, m[15:8]} + 9'd1;
        return c[5] ? (c[4] ? 9'd8 : 9'd4) : 9'd2;
    endfunction : expLen
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst, psel, penable, pwrite, masterMode} = 5'h10;
        paddr = 8'h0;
        pwdata = 32'h0;
        failures = 0;
        n_tests = 0;
        ver = {12'h0, lin_cfg_pkg::REVISION_RSVD, 4'h0, lin_cfg_pkg::REVISION_VALUE};
        void'($urandom(32'h7f19));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b1, 8'hfc, 32'hffff_ffff, d);
        foreach (regA[i]) begin
            apb(1'b0, regA[i], 32'h0, d);
            `CHK("reset value", (regA[i] == 8'hfc) ? ver : 32'h0, d)
        end
        $display("reset values done");
        masterMode <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            v = ($urandom & 32'h1ffdc) | (i & 3) | ((i & 4) << 3);
            id = 8'($urandom);
            apb(1'b1, 8'h58, {24'h0, id}, d);
            apb(1'b1, 8'h54, v, d);
            apb(1'b0, 8'h54, 32'h0, d);
            `CHK("lin mode", v, d)
            `CHK("length", expLen(v, id), responseLength)
            `CHK("action", {v[1:0] == 2'h0, v[1:0] == 2'h1}, {txResponse, rxResponse})
            `CHK("flags", {v[7], ~v[6], v[4], ~v[3], ~v[2]}, {wakeupLin13,
                frameSlotEnable, checksumClassic, checksumEnable, parityEnable})
        end
        apb(1'b1, 8'h60, 32'h1, d);
        `CHK("wakeup", 1'b1, wakeupPulse)
        $display("lin mode done");
        apb(1'b1, 8'h54, 32'h0, d);
        u_lin_node_model.dmaPut(17'h0a5);
        apb(1'b0, 8'h54, 32'h0, d);
        `CHK("dma off", 32'h0, d)
        apb(1'b1, 8'h54, 32'h10000, d);
        u_lin_node_model.dmaPut(17'h0a5);
        apb(1'b0, 8'h54, 32'h0, d);
        `CHK("dma on", 32'h100a5, d)
        $display("dma done");
        apb(1'b1, 8'h60, 32'h2, d);
        masterMode <= 1'b0;
        apb(1'b1, 8'h58, 32'h3c, d);
        u_lin_node_model.idEvent(1'b1, 8'h96);
        apb(1'b0, 8'h58, 32'h0, d);
        `CHK("slave id", 32'h96, d)
        `CHK("id flag", 1'b1, identifierSeenFlag)
        apb(1'b1, 8'h60, 32'h2, d);
        `CHK("id clear", 1'b0, identifierSeenFlag)
        masterMode <= 1'b1;
        u_lin_node_model.idEvent(1'b0, 8'h00);
        apb(1'b1, 8'h58, 32'h5a, d);
        apb(1'b0, 8'h58, 32'h0, d);
        `CHK("master id", {1'b1, 32'h5a}, {identifierSeenFlag, d})
        $display("identifier done");
        apb(1'b1, 8'he4, 32'h5553_4001, d);
        apb(1'b1, 8'h20, 32'h51234, d);
        apb(1'b1, 8'h24, 32'hffff_ffff, d);
        `CHK("timeout", 17'h1ffff, rxTimeoutValue)
        apb(1'b1, 8'he4, 32'h5553_4101, d);
        apb(1'b0, 8'he4, 32'h0, d);
        `CHK("key reads zero", 32'h1, d)
        foreach (gA[i]) begin
            apb(1'b1, gA[i], 32'h5a, d);
            apb(1'b0, 8'he8, 32'h0, d);
            `CHK("violation", {16'h0, gA[i], 8'h1}, d)
            apb(1'b0, 8'he8, 32'h0, d);
            `CHK("status cleared", 32'h0, d)
            apb(1'b0, gA[i], 32'h0, d);
            `CHK("blocked", gE[i], d)
        end
        `CHK("mode out", 32'h0, modeValue)
        apb(1'b1, 8'he4, 32'h5553_4100, d);
        apb(1'b1, 8'h28, 32'h7f, d);
        `CHK("unguarded", 8'h7f, guardValue)
        apb(1'b0, 8'h40, 32'h0, d);
        `CHK("unmapped", 1'b1, serr)
        $display("protection done");
        final_report();
    end
endmodule : tb_top
bind lin_frame_config_write_protect lin_cfg_asserts u_lin_cfg_asserts (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .idSent(idSent), .responseLength(responseLength), .wakeupPulse(wakeupPulse),
    .checksumClassic(checksumClassic), .checksumEnable(checksumEnable),
    .parityEnable(parityEnable), .txResponse(txResponse), .rxResponse(rxResponse),
    .identifierSeenFlag(identifierSeenFlag), .baudValue(baudValue),
    .dividedClockTick(dividedClockTick));
